// File: hw/secp_top.sv
`timescale 1ns/1ps
`default_nettype none
module secp_top import secp_pkg::*; #(
    parameter int unsigned ADDR_W = ADDR_W_DEF,
    parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DEF
) (
    // system
    input wire logic i_clk,
    input wire logic i_rst,
    // serial link
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe,
    // write protect pin
    input wire logic i_wp_n,
    // non-volatile protect bits backing store and write busy
    input wire secp_nv_t i_nv_restore,
    output secp_nv_t o_nv_status,
    output logic o_write_busy
);
    localparam int unsigned DEPTH = 2 ** ADDR_W;
    localparam int unsigned TMR_W = $clog2(WRITE_CYCLES + 1);
    localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(WRITE_CYCLES - 1);

    if (ADDR_W < 6 || ADDR_W > 16) begin : g_bad_addr
        $error("ADDR_W must lie between 6 and 16");
    end
    if (WRITE_CYCLES < 1) begin : g_bad_cycles
        $error("WRITE_CYCLES must be at least 1");
    end

    typedef struct packed {
        logic cs_n_d;
        logic seen_tog;
        secp_nv_t nv;
        logic latch;
        logic busy;
        logic [TMR_W-1:0] timer;
        logic [DEPTH-1:0][7:0] mem;
    } secp_core_t;

    secp_core_t core_reg, core_next, core_rst;
    secp_frame_t frame;
    secp_status_t status;
    logic [2:0] pin_s;
    logic cs_n_s;
    logic wp_n_s;
    logic tog_s;
    logic commit;
    logic hw_protect;
    logic target_prot;

    function automatic logic blk_protected(logic [ADDR_W-1:0] a, logic [1:0] bp);
        logic p;
        case (bp)
            PROTECT_NONE: p = 1'b0;
            PROTECT_QUARTER: p = (a[ADDR_W-1:ADDR_W-2] == TOP_QUARTER);
            PROTECT_HALF: p = a[ADDR_W-1];
            default: p = 1'b1;
        endcase
        return p;
    endfunction

    secp_sync #(.W(3)) u_pin_sync (
        .i_clk(i_clk),
        .i_d({i_cs_n, i_wp_n, frame.frame_tog}),
        .o_q(pin_s)
    );

    assign cs_n_s = pin_s[2];
    assign wp_n_s = pin_s[1];
    assign tog_s = pin_s[0];

    secp_link #(.ADDR_W(ADDR_W)) u_link (
        .i_sck(i_sck),
        .i_cs_n(i_cs_n),
        .i_si(i_si),
        .o_so(o_so),
        .o_so_oe(o_so_oe),
        .i_rst(i_rst),
        .i_status(status),
        .i_mem(core_reg.mem),
        .o_frame(frame)
    );

    always_comb begin
        status.nv = core_reg.nv;
        status.write_latch_state = core_reg.latch;
        status.write_busy_flag = core_reg.busy;
    end

    always_comb begin
        core_rst = '0;
        core_rst.cs_n_d = 1'b1;
        core_rst.nv = i_nv_restore;
        core_rst.mem = {DEPTH{ERASED_BYTE}};
    end

    always_comb begin
        core_next = core_reg;
        core_next.cs_n_d = cs_n_s;
        // only a deselect after a clocked frame commits anything
        commit = !core_reg.cs_n_d && cs_n_s && (tog_s != core_reg.seen_tog);
        hw_protect = !wp_n_s && core_reg.nv.protect_pin_enable;
        target_prot = blk_protected(frame.addr[ADDR_W-1:0], core_reg.nv.block_protect);
        if (core_reg.busy) begin
            if (core_reg.timer == TMR_LAST) begin
                core_next.busy = 1'b0;
                core_next.latch = 1'b0;
                core_next.timer = '0;
            end else begin
                core_next.timer = core_reg.timer + 1'b1;
            end
        end
        if (commit) begin
            core_next.seen_tog = tog_s;
            if (frame.boundary) begin
                case (frame.opcode)
                    LATCH_SET_CMD: begin
                        if (frame.nbytes == CNT_OPCODE) begin
                            core_next.latch = 1'b1;
                        end
                    end
                    LATCH_CLEAR_CMD: begin
                        if (frame.nbytes == CNT_OPCODE) begin
                            core_next.latch = 1'b0;
                        end
                    end
                    STATUS_WRITE_CMD: begin
                        // protect pin is looked at here only
                        if (frame.nbytes == CNT_ADDR_HI && !core_reg.busy
                                && core_reg.latch && !hw_protect) begin
                            core_next.nv.protect_pin_enable =
                                frame.status_data[PROTECT_PIN_ENABLE_POS];
                            core_next.nv.block_protect = {
                                frame.status_data[BLOCK_PROTECT_HI_POS],
                                frame.status_data[BLOCK_PROTECT_LO_POS]};
                            core_next.busy = 1'b1;
                            core_next.timer = '0;
                        end
                    end
                    ARRAY_WRITE_CMD: begin
                        // refused writes do not set busy
                        if (frame.nbytes == CNT_SAT && !core_reg.busy
                                && core_reg.latch && !target_prot) begin
                            for (int i = 0; i < PAGE_BYTES; i++) begin
                                if (frame.mask[i]) begin
                                    core_next.mem[{frame.addr[ADDR_W-1:PAGE_IDX_W],
                                        PAGE_IDX_W'(i)}] = frame.page[i];
                                end
                            end
                            core_next.busy = 1'b1;
                            core_next.timer = '0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // latch starts clear, busy low and protect bits restored after reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            core_reg <= core_rst;
        end else begin
            core_reg <= core_next;
        end
    end

    assign o_nv_status = core_reg.nv;
    assign o_write_busy = core_reg.busy;
endmodule
`default_nettype wire

// File: hw/secp_pkg.sv
// Function
// - internal write only with latch set
// - opcode 06h sets, 04h clears latch
// - 05h reads status, 01h writes protect bits
// - 03h reads array, 02h writes array
// - latch cleared at reset and after writes
// - status readable even during internal write
// - status byte bit layout fixed
// - busy bit reflects internal write, read-only
// - latch bit changed only by latch commands, reset and write end
// - protect bits persist, status write only
// - hardware protect: pin low and enable high
// - write matrix: latch, blocks, status register
// - block protect codes select top fractions
// - sample on rise, shift out after fall
// - opcode then 16-bit address, top bits ignored
// - read address increments and wraps to zero
// - read runs until deselect
// - latch set only on deselect after opcode
// - page write wraps within sixteen bytes
// - write starts only on byte boundary deselect
// - array access ignored while write runs
// - power-up standby, latch clear, output off
// - self-timed write within five milliseconds
// - protect pin ignored once cycle started
// - output released while deselected
package secp_pkg;
    localparam logic [7:0] LATCH_SET_CMD = 8'h06;
    localparam logic [7:0] LATCH_CLEAR_CMD = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
    localparam logic [7:0] ARRAY_WRITE_CMD = 8'h02;

    localparam int unsigned PROTECT_PIN_ENABLE_POS = 7;
    localparam int unsigned BLOCK_PROTECT_HI_POS = 3;
    localparam int unsigned BLOCK_PROTECT_LO_POS = 2;
    localparam int unsigned WRITE_LATCH_STATE_POS = 1;
    localparam int unsigned WRITE_BUSY_FLAG_POS = 0;

    localparam logic [1:0] PROTECT_NONE = 2'h0;
    localparam logic [1:0] PROTECT_QUARTER = 2'h1;
    localparam logic [1:0] PROTECT_HALF = 2'h2;
    localparam logic [1:0] TOP_QUARTER = 2'h3;

    // count of complete bytes in a frame
    localparam logic [2:0] CNT_OPCODE = 3'h1;
    localparam logic [2:0] CNT_ADDR_HI = 3'h2;
    localparam logic [2:0] CNT_SAT = 3'h4;

    localparam int unsigned PAGE_BYTES = 16;
    localparam int unsigned PAGE_IDX_W = 4;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam int unsigned ADDR_W_DEF = 10;

    localparam int unsigned WRITE_TIME_MS = 5;
    localparam int unsigned CLK_FREQ_KHZ = 200000;
    localparam int unsigned WRITE_CYCLES_DEF = WRITE_TIME_MS * CLK_FREQ_KHZ;

    typedef struct packed {
        logic protect_pin_enable;
        logic [1:0] block_protect;
    } secp_nv_t;

    typedef struct packed {
        secp_nv_t nv;
        logic write_latch_state;
        logic write_busy_flag;
    } secp_status_t;

    // frame record left behind by the serial side for the core
    typedef struct packed {
        logic frame_tog;
        logic [7:0] opcode;
        logic [2:0] nbytes;
        logic boundary;
        logic [15:0] addr;
        logic [7:0] status_data;
        logic [PAGE_BYTES-1:0] mask;
        logic [PAGE_BYTES-1:0][7:0] page;
    } secp_frame_t;

    typedef struct packed {
        logic started;
        logic [2:0] bitcnt;
        logic [6:0] shift;
        logic [2:0] nbytes;
        logic [15:0] addr;
        logic [7:0] out_byte;
        logic out_en;
    } secp_shift_t;

    typedef struct packed {
        logic so;
        logic oe;
    } secp_pin_t;

    function automatic logic [7:0] secp_status_byte(secp_status_t s);
        logic [7:0] b;
        b = 8'h00;
        b[PROTECT_PIN_ENABLE_POS] = s.nv.protect_pin_enable;
        b[BLOCK_PROTECT_HI_POS] = s.nv.block_protect[1];
        b[BLOCK_PROTECT_LO_POS] = s.nv.block_protect[0];
        b[WRITE_LATCH_STATE_POS] = s.write_latch_state;
        b[WRITE_BUSY_FLAG_POS] = s.write_busy_flag;
        return b;
    endfunction
endpackage

// File: hw/secp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module secp_sync #(
    parameter int unsigned W = 1
) (
    // clock
    input wire logic i_clk,
    // data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [1:0][W-1:0] stage_reg;

    always_ff @(posedge i_clk) begin
        stage_reg <= {stage_reg[0], i_d};
    end

    assign o_q = stage_reg[1];
endmodule
`default_nettype wire

// File: hw/secp_link.sv
`timescale 1ns/1ps
`default_nettype none
module secp_link import secp_pkg::*; #(
    parameter int unsigned ADDR_W = ADDR_W_DEF
) (
    // serial pins
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe,
    // core side
    input wire logic i_rst,
    input wire secp_status_t i_status,
    input wire logic [(2**ADDR_W)-1:0][7:0] i_mem,
    output secp_frame_t o_frame
);
    secp_shift_t sh_reg, sh_next;
    secp_frame_t fr_reg, fr_next;
    secp_pin_t pin_reg, pin_next;
    secp_status_t st_sync;
    logic [7:0] byte_in;
    logic [15:0] addr_full;
    logic last_bit;

    // status is quasi-static; it settles over the opcode clocks
    secp_sync #(.W($bits(secp_status_t))) u_status_sync (
        .i_clk(i_sck),
        .i_d(i_status),
        .o_q(st_sync)
    );

    always_comb begin
        sh_next = sh_reg;
        fr_next = fr_reg;
        byte_in = {sh_reg.shift, i_si};
        addr_full = {sh_reg.addr[15:8], byte_in};
        last_bit = (sh_reg.bitcnt == 3'h7);
        sh_next.started = 1'b1;
        sh_next.bitcnt = sh_reg.bitcnt + 3'h1;
        sh_next.shift = byte_in[6:0];
        fr_next.boundary = last_bit;
        if (!sh_reg.started) begin
            fr_next.frame_tog = ~fr_reg.frame_tog;
            fr_next.mask = '0;
        end
        if (last_bit) begin
            if (sh_reg.nbytes != CNT_SAT) begin
                sh_next.nbytes = sh_reg.nbytes + 3'h1;
            end
            // reload the output byte while a read runs
            if (sh_reg.out_en) begin
                if (fr_reg.opcode == STATUS_READ_CMD) begin
                    sh_next.out_byte = secp_status_byte(st_sync);
                end else begin
                    sh_next.out_byte = i_mem[sh_reg.addr[ADDR_W-1:0]];
                    sh_next.addr = sh_reg.addr + 16'h0001;
                end
            end
            case (sh_reg.nbytes)
                3'h0: begin
                    fr_next.opcode = byte_in;
                    // status answers even during an internal write
                    if (byte_in == STATUS_READ_CMD) begin
                        sh_next.out_byte = secp_status_byte(st_sync);
                        sh_next.out_en = 1'b1;
                    end
                end
                CNT_OPCODE: begin
                    sh_next.addr[15:8] = byte_in;
                    if (fr_reg.opcode == STATUS_WRITE_CMD) begin
                        fr_next.status_data = byte_in;
                    end
                end
                CNT_ADDR_HI: begin
                    sh_next.addr = addr_full;
                    fr_next.addr = addr_full;
                    // array reads are dropped while a write cycle runs
                    if (fr_reg.opcode == ARRAY_READ_CMD && !st_sync.write_busy_flag) begin
                        sh_next.out_byte = i_mem[addr_full[ADDR_W-1:0]];
                        sh_next.out_en = 1'b1;
                        sh_next.addr = addr_full + 16'h0001;
                    end
                end
                default: begin
                    if (fr_reg.opcode == ARRAY_WRITE_CMD) begin
                        fr_next.page[sh_reg.addr[PAGE_IDX_W-1:0]] = byte_in;
                        fr_next.mask[sh_reg.addr[PAGE_IDX_W-1:0]] = 1'b1;
                        // wrap inside the page
                        sh_next.addr[PAGE_IDX_W-1:0] = sh_reg.addr[PAGE_IDX_W-1:0] + 4'h1;
                    end
                end
            endcase
        end
        fr_next.nbytes = sh_next.nbytes;
    end

    // frame state restarts with every select
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            sh_reg <= '0;
        end else begin
            sh_reg <= sh_next;
        end
    end

    always_ff @(posedge i_sck or posedge i_rst) begin
        if (i_rst) begin
            fr_reg <= '0;
        end else begin
            fr_reg <= fr_next;
        end
    end

    always_comb begin
        pin_next.so = sh_reg.out_byte[~sh_reg.bitcnt];
        pin_next.oe = sh_reg.out_en;
    end

    // output released the moment select goes high
    always_ff @(negedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            pin_reg <= '0;
        end else begin
            pin_reg <= pin_next;
        end
    end

    assign o_so = pin_reg.so;
    assign o_so_oe = pin_reg.oe;
    assign o_frame = fr_reg;
endmodule
`default_nettype wire

// File: dv/secp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module secp_host_model (
    // serial pins
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si,
    input wire logic i_so,
    input wire logic i_so_oe
);
    logic [7:0] txq[$];
    logic [7:0] rxq[$];
    logic [7:0] rx;
    logic oe_seen;

    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
        rx = 8'h00;
        oe_seen = 1'b0;
    end

    // one mode 0 frame; clock idles low outside frames
    task automatic frame(input int nbits);
        logic [7:0] b;
        rxq.delete();
        oe_seen = 1'b0;
        o_cs_n = 1'b0;
        #100;
        for (int k = 0; k < nbits; k++) begin
            b = (k / 8 < txq.size()) ? txq[k / 8] : 8'h00;
            o_si = b[7 - k % 8];
            #15 o_sck = 1'b1;
            // a released output line carries no trustworthy level
            rx = {rx[6:0], i_so_oe ? i_so : ~i_so};
            oe_seen = oe_seen | i_so_oe;
            if (k % 8 == 7) rxq.push_back(rx);
            #15 o_sck = 1'b0;
        end
        #100;
        o_cs_n = 1'b1;
        // released data line shows no stale level
        o_si = ~o_si;
        txq.delete();
        #300;
    endtask
endmodule
`default_nettype wire

// File: dv/secp_props.sv
`timescale 1ns/1ps
`default_nettype none
module secp_props import secp_pkg::*; #(
    parameter int unsigned ADDR_W = ADDR_W_DEF,
    parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DEF
) (
    // system
    input wire logic i_clk,
    input wire logic i_rst,
    // serial link
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic o_so,
    input wire logic o_so_oe,
    // protect bits and busy
    input wire secp_nv_t i_nv_restore,
    input wire secp_nv_t o_nv_status,
    input wire logic o_write_busy
);
    logic [31:0] busy_cnt_reg;

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // cycles spent busy in the current internal write
    always_ff @(posedge i_clk) begin
        if (i_rst || !o_write_busy) begin
            busy_cnt_reg <= 32'h0;
        end else begin
            busy_cnt_reg <= busy_cnt_reg + 32'h1;
        end
    end

    sequence deselected_s;
        i_cs_n && !$past(i_cs_n, 12);
    endsequence

    sequence busy_hold_s;
        o_write_busy [*8];
    endsequence

    so_release_a: assert property (i_cs_n && $past(i_cs_n) |-> !o_so_oe)
        else $error("serial output driven while deselected");
    reset_idle_a: assert property ($fell(i_rst) |-> !o_write_busy)
        else $error("busy after reset");
    nv_restore_a: assert property ($fell(i_rst) |-> o_nv_status == $past(i_nv_restore))
        else $error("protect bits not restored");
    busy_start_a: assert property ($rose(o_write_busy) |-> deselected_s)
        else $error("write cycle not started by deselect");
    busy_hold_a: assert property ($rose(o_write_busy) |=> busy_hold_s)
        else $error("write cycle cut short");
    busy_length_a: assert property ($fell(o_write_busy) |-> busy_cnt_reg == WRITE_CYCLES)
        else $error("write cycle length wrong");
    busy_bound_a: assert property (busy_cnt_reg <= WRITE_CYCLES)
        else $error("write cycle overran");
    nv_commit_a: assert property ($changed(o_nv_status) |-> o_write_busy || $past(o_write_busy))
        else $error("protect bits changed outside status write");
    so_steady_a: assert property (!i_cs_n && i_sck && $past(i_sck) |-> $stable({o_so, o_so_oe}))
        else $error("serial output changed while clock high");
endmodule

bind secp_top secp_props #(.ADDR_W(ADDR_W), .WRITE_CYCLES(WRITE_CYCLES)) secp_props_i (
    .i_clk, .i_rst, .i_sck, .i_cs_n, .o_so, .o_so_oe,
    .i_nv_restore, .o_nv_status, .o_write_busy
);
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import secp_pkg::*;;
    localparam int unsigned WCYC = 600;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic wp_n = 1'b1;
    logic sck, cs_n, si, so, so_oe, busy;
    secp_nv_t nv;
    int fails = 0;
    int checked = 0;

    always #2.5 i_clk = ~i_clk;

    secp_top #(.ADDR_W(10), .WRITE_CYCLES(WCYC)) secp_top_i (
        .i_clk(i_clk), .i_rst(i_rst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
        .o_so(so), .o_so_oe(so_oe), .i_wp_n(wp_n), .i_nv_restore(3'h0),
        .o_nv_status(nv), .o_write_busy(busy)
    );

    secp_host_model secp_host_model_i (
        .o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic xfer(input logic [47:0] v, input int nbits);
        int nb;
        nb = (nbits + 7) / 8;
        @(posedge i_clk);
        #1;
        for (int i = 0; i < nb; i++) begin
            secp_host_model_i.txq.push_back(v[8 * (nb - 1 - i) +: 8]);
        end
        secp_host_model_i.frame(nbits);
    endtask

    task automatic rd_status(input logic [7:0] exp);
        xfer(16'h0500, 16);
        check(secp_host_model_i.rxq[1], exp);
    endtask

    task automatic chk_busy(input logic e);
        check({7'h0, busy}, {7'h0, e});
    endtask

    task automatic set_wp(input logic v);
        @(posedge i_clk);
        #1 wp_n = v;
    endtask

    task automatic wait_idle();
        for (int n = 0; n < 1000 && busy !== 1'b0; n++) begin
            @(posedge i_clk);
            #1;
        end
        chk_busy(1'b0);
    endtask

    initial begin
        repeat (16) @(posedge i_clk);
        #1 i_rst = 1'b0;
        repeat (3) @(posedge i_clk);
        rd_status(8'h00);
        xfer(32'h02_0010_5a, 32);
        chk_busy(1'b0);
        xfer(8'h06, 8);
        rd_status(8'h02);
        xfer(8'h04, 8);
        rd_status(8'h00);
        xfer(16'h06_02, 16);
        rd_status(8'h00);
        xfer(8'h06, 8);
        xfer(40'h02_03fe_a1_00, 36);
        chk_busy(1'b0);
        xfer(48'h02_03fe_a1b2c3, 48);
        chk_busy(1'b1);
        xfer(32'h03_03fe_00, 32);
        check({7'h0, secp_host_model_i.oe_seen}, 8'h00);
        rd_status(8'h03);
        wait_idle();
        rd_status(8'h00);
        xfer(48'h03_03fe_000000, 48);
        check(secp_host_model_i.rxq[3], 8'ha1);
        check(secp_host_model_i.rxq[4], 8'hb2);
        check(secp_host_model_i.rxq[5], 8'hff);
        xfer(32'h03_03f0_00, 32);
        check(secp_host_model_i.rxq[3], 8'hc3);
        xfer(8'h06, 8);
        xfer(16'h01_8c, 16);
        chk_busy(1'b1);
        wait_idle();
        check({5'h0, nv}, 8'h07);
        rd_status(8'h8c);
        xfer(8'h06, 8);
        xfer(32'h02_0000_77, 32);
        chk_busy(1'b0);
        set_wp(1'b0);
        xfer(16'h01_84, 16);
        chk_busy(1'b0);
        rd_status(8'h8e);
        set_wp(1'b1);
        xfer(16'h01_84, 16);
        chk_busy(1'b1);
        set_wp(1'b0);
        wait_idle();
        check({5'h0, nv}, 8'h05);
        xfer(8'h06, 8);
        xfer(32'h02_0300_11, 32);
        chk_busy(1'b0);
        xfer(32'h02_02ff_22, 32);
        chk_busy(1'b1);
        wait_idle();
        conclude();
    end

    // tests need about 40 us; allow several times that
    initial begin
        #400000;
        fails++;
        conclude();
    end
endmodule
`default_nettype wire
